// *** core/mufs_top.sv ***
/*
 * Control and status registers of a small serial port: modem status,
 * scratch byte, extra control and extended status, with transmit flow
 * gating, receive start enable and the ready-to-receive output line.
 * Assumes an APB master on pclk, a data path on the same clock that
 * reports FIFO counts and busy flags and asks before starting a symbol,
 * and a remote peer driving flow_in_pin asynchronously.
 */
// The address map and the APB interface to the registers are this design's own decisions.
`include "mufs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module mufs_top #(
   parameter int CNT_W = 4
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                flow_in_pin,
   output logic                     flow_out_pin,
   input  wire mufs_pkg::mufs_path_t path,
   input  wire logic                tx_start_req,
   output logic                     tx_start,
   input  wire logic                rx_start_req,
   output logic                     rx_start,
   input  wire logic                rx_drop,
   input  wire logic                lsr_rd,
   input  wire logic                mcr_rts
);

   // ***************************************************************
   // Declarations.
   // ***************************************************************
   mufs_pkg::mufs_cntl_t cntl;
   mufs_pkg::mufs_cntl_t next_cntl;
   logic [7:0]           scratch;
   logic [7:0]           next_scratch;
   logic [31:0]          next_prdata;
   logic                 overrun;
   logic                 next_overrun;
   logic                 cts_meta;
   logic                 cts_s;
   logic                 next_flow_out;
   logic                 cts_asserted;
   logic                 rx_ready;
   logic [CNT_W-1:0]     rx_free;
   logic [31:0]          stat_word;
   logic                 setup_ph;
   logic                 wr_acc;
   logic                 mapped;

   // Free-slot count at which the ready line drops.
   function automatic logic [3:0] thr_free(input logic [1:0] code);
      logic [3:0] r;
      r = `MUFS_THR_00;
      unique case (code)
         2'b00: r = `MUFS_THR_00;
         2'b01: r = `MUFS_THR_01;
         2'b10: r = `MUFS_THR_10;
         2'b11: r = `MUFS_THR_11;
      endcase
      return r;
   endfunction

   // Address decode shared by the write path and the error answer.
   function automatic logic is_mapped(input logic [7:0] a);
      return (a == `MUFS_OFF_MODEM) || (a == `MUFS_OFF_SCRATCH) ||
             (a == `MUFS_OFF_CNTL) || (a == `MUFS_OFF_STAT);
   endfunction

   // ***************************************************************
   // Clear-to-send synchroniser.
   // ***************************************************************
   // The pin is asynchronous, so two flops come before any use.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cts_meta <= 1'b0;
         cts_s    <= 1'b0;
      end else begin
         cts_meta <= flow_in_pin;
         cts_s    <= cts_meta;
      end
   end

   // Asserted level follows the polarity bit.
   always_comb begin
      cts_asserted = cts_s ^ cntl.cts_lvl;
   end

   // ***************************************************************
   // APB decode.
   // ***************************************************************
   // Zero wait states: read data is captured in the setup cycle.
   // An error shows only in the access phase, beside pready.
   always_comb begin
      setup_ph = psel && !penable;
      mapped   = is_mapped(paddr);
      pready   = psel && penable;
      pslverr  = psel && penable && !mapped;
      wr_acc   = psel && penable && pwrite && mapped;
   end

   // ***************************************************************
   // Control and scratch registers.
   // ***************************************************************
   // Only byte lane 0 carries fields; upper lanes are ignored.
   always_comb begin
      next_cntl    = cntl;
      next_scratch = scratch;
      if (wr_acc && pstrb[0]) begin
         if (paddr == `MUFS_OFF_CNTL) begin
            next_cntl = mufs_pkg::mufs_cntl_t'(pwdata[7:0]);
         end
         if (paddr == `MUFS_OFF_SCRATCH) begin
            next_scratch = pwdata[7:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cntl    <= mufs_pkg::mufs_cntl_t'(`MUFS_CNTL_RST);
         scratch <= `MUFS_SCR_RST;
      end else begin
         cntl    <= next_cntl;
         scratch <= next_scratch;
      end
   end

   // ***************************************************************
   // Overrun flag.
   // ***************************************************************
   // A drop in the same cycle as the clear wins, so none is lost.
   always_comb begin
      next_overrun = overrun;
      if (lsr_rd) begin
         next_overrun = 1'b0;
      end
      if (rx_drop) begin
         next_overrun = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overrun <= 1'b0;
      end else begin
         overrun <= next_overrun;
      end
   end

   // ***************************************************************
   // Symbol start gating.
   // ***************************************************************
   // Only starts are gated; a symbol already on the wire runs on.
   always_comb begin
      tx_start = tx_start_req && cntl.tx_en &&
                 (!cntl.tx_auto || cts_asserted);
      rx_start = rx_start_req && cntl.rx_en;
   end

   // ***************************************************************
   // Ready-to-receive output line.
   // ***************************************************************
   // Dropping a few slots early leaves room for symbols in flight.
   always_comb begin
      rx_free  = CNT_W'(`MUFS_FIFO_DEPTH) - path.rx_count;
      rx_ready = rx_free > thr_free(cntl.thr);
      if (cntl.rx_auto) begin
         next_flow_out = rx_ready ^ cntl.rts_lvl;
      end else begin
         next_flow_out = !mcr_rts;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flow_out_pin <= 1'b1;
      end else begin
         flow_out_pin <= next_flow_out;
      end
   end

   // ***************************************************************
   // Extended status word.
   // ***************************************************************
   // Every field is live; only the overrun bit is stored here.
   // Counts above eight from the data path are passed on unchecked.
   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[`MUFS_ST_TXLVL_LO +: 4] = path.tx_count;
      stat_word[`MUFS_ST_RXLVL_LO +: 4] = path.rx_count;
      stat_word[`MUFS_ST_TXEMPTY] = path.tx_count == 4'h0;
      stat_word[`MUFS_ST_TXIDLE]  = !path.tx_busy;
      stat_word[`MUFS_ST_DONE]    = !path.tx_busy &&
                                    path.tx_count == 4'h0;
      stat_word[`MUFS_ST_CTS]     = cts_s;
      stat_word[`MUFS_ST_RTS]     = flow_out_pin;
      stat_word[`MUFS_ST_SPACE]   =
         path.tx_count != 4'(`MUFS_FIFO_DEPTH);
      stat_word[`MUFS_ST_TXFULL]  =
         path.tx_count == 4'(`MUFS_FIFO_DEPTH);
      stat_word[`MUFS_ST_OVR]     = overrun;
      stat_word[`MUFS_ST_RXIDLE]  = !path.rx_busy;
      stat_word[`MUFS_ST_AVAIL]   = path.rx_count != 4'h0;
   end

   // ***************************************************************
   // Read data register.
   // ***************************************************************
   // Reads have no side effect; unmapped offsets return zero.
   always_comb begin
      next_prdata = prdata;
      if (setup_ph && !pwrite) begin
         next_prdata = 32'h0000_0000;
         unique case (paddr)
            `MUFS_OFF_MODEM:
               next_prdata[`MUFS_MSR_CTS] = !cts_s;
            `MUFS_OFF_SCRATCH:
               next_prdata[7:0] = scratch;
            `MUFS_OFF_CNTL:
               next_prdata[7:0] = cntl;
            `MUFS_OFF_STAT:
               next_prdata = stat_word;
            default:
               next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= next_prdata;
      end
   end

   // ***************************************************************
   // Assertions and cover points.
   // ***************************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Modem status read carries the inverted synchronised pin.
   modem_cts_inv_a: assert property (
      setup_ph && !pwrite && paddr == `MUFS_OFF_MODEM |=>
         prdata[`MUFS_MSR_CTS] == !$past(cts_s))
      else $error("modem status cts bit not inverted");

   // Scratch changes only through a write access.
   scratch_hold_a: assert property (
      !(wr_acc && paddr == `MUFS_OFF_SCRATCH) |=> $stable(scratch))
      else $error("scratch changed without a write");

   // Scratch write lands one edge later.
   scratch_write_a: assert property (
      wr_acc && pstrb[0] && paddr == `MUFS_OFF_SCRATCH |=>
         scratch == $past(pwdata[7:0]))
      else $error("scratch write lost");

   // No transmit start while auto flow sees deasserted line.
   cts_gate_a: assert property (
      cntl.tx_auto && (cts_s == cntl.cts_lvl) |-> !tx_start)
      else $error("transmit started against flow line");

   // Transmitter off means no new start.
   tx_enable_a: assert property (
      !cntl.tx_en |-> !tx_start)
      else $error("transmit started while disabled");

   // Receiver off means no new start.
   rx_enable_a: assert property (
      !cntl.rx_en |-> !rx_start)
      else $error("receive started while disabled");

   // Auto flow drops the line to its deasserted level at threshold.
   rts_auto_a: assert property (
      cntl.rx_auto && rx_free <= thr_free(cntl.thr) |=>
         flow_out_pin == $past(cntl.rts_lvl))
      else $error("ready line not deasserted at threshold");

   // Auto flow holds the line asserted above threshold.
   rts_ready_a: assert property (
      cntl.rx_auto && rx_free > thr_free(cntl.thr) |=>
         flow_out_pin == !$past(cntl.rts_lvl))
      else $error("ready line not asserted with room");

   // Manual mode: bit set drives low.
   rts_manual_a: assert property (
      !cntl.rx_auto |=> flow_out_pin == !$past(mcr_rts))
      else $error("manual ready line wrong level");

   // Drop sets the flag, even beside a clear.
   ovr_set_a: assert property (
      rx_drop |=> overrun)
      else $error("overrun flag not set");

   // Clear without a drop empties it and it stays until a drop.
   ovr_clear_a: assert property (
      lsr_rd && !rx_drop |=> !overrun)
      else $error("overrun flag not cleared");

   // Done bit is the AND of idle and empty.
   done_and_a: assert property (
      stat_word[`MUFS_ST_DONE] ==
         (stat_word[`MUFS_ST_TXIDLE] && stat_word[`MUFS_ST_TXEMPTY]))
      else $error("done bit mismatch");

   // Full is the inverse of space available.
   full_space_a: assert property (
      stat_word[`MUFS_ST_TXFULL] != stat_word[`MUFS_ST_SPACE])
      else $error("full and space bits agree");

   // Pin reaches logic after exactly two edges.
   sync_delay_a: assert property (
      $past(presetn, 2) |-> cts_s == $past(flow_in_pin, 2))
      else $error("synchroniser delay wrong");

   // Unmapped access answers with an error.
   unmapped_err_a: assert property (
      psel && penable && !is_mapped(paddr) |-> pready && pslverr)
      else $error("unmapped access not refused");

   // Status reads leave the flag alone; only a drop or a clear moves it.
   ovr_hold_a: assert property (
      !lsr_rd && !rx_drop |=> $stable(overrun))
      else $error("overrun flag moved without cause");

   // Status read carries both fill levels as they stood at setup.
   stat_level_a: assert property (
      setup_ph && !pwrite && paddr == `MUFS_OFF_STAT |=>
         prdata[`MUFS_ST_TXLVL_LO +: 4] == $past(path.tx_count) &&
         prdata[`MUFS_ST_RXLVL_LO +: 4] == $past(path.rx_count))
      else $error("fill levels lost on status read");

   // With transmit auto flow off the line is ignored.
   tx_pass_a: assert property (
      tx_start_req && cntl.tx_en && !cntl.tx_auto |-> tx_start)
      else $error("transmit start held back without cause");

   // An enabled receiver always takes the start request.
   rx_pass_a: assert property (
      rx_start_req && cntl.rx_en |-> rx_start)
      else $error("receive start held back while enabled");

   // Control write lands one edge later, all eight bits.
   cntl_write_a: assert property (
      wr_acc && pstrb[0] && paddr == `MUFS_OFF_CNTL |=>
         cntl == mufs_pkg::mufs_cntl_t'($past(pwdata[7:0])))
      else $error("control write lost");

   // Modem status read leaves every other bit at zero.
   modem_rsvd_a: assert property (
      setup_ph && !pwrite && paddr == `MUFS_OFF_MODEM |=>
         prdata[31:5] == 27'h0 && prdata[3:0] == 4'h0)
      else $error("modem status reserved bits set");

   // Main scenarios that the bench is expected to reach.
   pause_c: cover property (tx_start_req && cntl.tx_en && !tx_start);
   rts_drop_c: cover property (cntl.rx_auto ##1 $fell(flow_out_pin));
   overrun_c: cover property (rx_drop ##1 lsr_rd ##1 !overrun);
   cntl_wr_c: cover property (wr_acc && paddr == `MUFS_OFF_CNTL);
   unmapped_c: cover property (pslverr);

endmodule

`default_nettype wire

// *** core/mufs_map.svh ***
/*
 * Register offsets, field positions, reset values and counts for the
 * serial port flow-control and status block.
 * Assumes it is included by its bare name from every file that needs it.
 */
// Overview of operation
// - Modem status bit 4 shows inverted clear-to-send
// - Eight-bit scratch byte, storage only, resets zero
// - Control bit 7 sets clear-to-send asserted level
// - Control bit 6 sets ready line asserted level
// - Bits 5:4 pick receive free-slot threshold
// - Bit 3 pauses new symbols on deasserted CTS
// - Symbol in progress finishes before pausing
// - Bit 2 drops ready line at threshold
// - Bit 1 enables transmitter, resets to one
// - Bit 0 enables receiver, current symbol completes
// - Status 27:24 give transmit FIFO count
// - Status 19:16 give receive FIFO count
// - Status bit 9 is idle AND empty
// - Status bit 8 flags empty transmit FIFO
// - Status bit 7 shows clear-to-send line
// - Status bit 6 shows ready output line
// - Status bit 5 is inverse of bit 1
// - Status bit 4 sticky overrun, line-status read clears
// - Status bit 3 set while transmitter idle
// - Status bit 2 set while receiver idle
// - Status bit 1 flags transmit space available
// - Status bit 0 flags receive symbol available
// - Manual bit drives request line low when set
`ifndef MUFS_MAP_SVH
`define MUFS_MAP_SVH

// ***************************************************************
// Register byte offsets.
// ***************************************************************
`define MUFS_OFF_MODEM   8'h00
`define MUFS_OFF_SCRATCH 8'h04
`define MUFS_OFF_CNTL    8'h08
`define MUFS_OFF_STAT    8'h0c

// ***************************************************************
// Field positions.
// ***************************************************************
`define MUFS_MSR_CTS     4
`define MUFS_ST_TXLVL_LO 24
`define MUFS_ST_RXLVL_LO 16
`define MUFS_ST_DONE     9
`define MUFS_ST_TXEMPTY  8
`define MUFS_ST_CTS      7
`define MUFS_ST_RTS      6
`define MUFS_ST_TXFULL   5
`define MUFS_ST_OVR      4
`define MUFS_ST_TXIDLE   3
`define MUFS_ST_RXIDLE   2
`define MUFS_ST_SPACE    1
`define MUFS_ST_AVAIL    0

// ***************************************************************
// Reset values and thresholds.
// ***************************************************************
`define MUFS_CNTL_RST    8'h03
`define MUFS_SCR_RST     8'h00
`define MUFS_FIFO_DEPTH  8
`define MUFS_THR_00      4'h3
`define MUFS_THR_01      4'h2
`define MUFS_THR_10      4'h1
`define MUFS_THR_11      4'h4

`endif

// *** core/mufs_pkg.sv ***
/*
 * Types shared by the flow-control and status block.
 * Assumes the map header supplies every number.
 */
package mufs_pkg;

   // Extra control register, bit 7 down to bit 0.
   typedef struct packed {
      logic       cts_lvl;
      logic       rts_lvl;
      logic [1:0] thr;
      logic       tx_auto;
      logic       rx_auto;
      logic       tx_en;
      logic       rx_en;
   } mufs_cntl_t;

   // Status coming from the data path on the same clock.
   typedef struct packed {
      logic [3:0] tx_count;
      logic [3:0] rx_count;
      logic       tx_busy;
      logic       rx_busy;
   } mufs_path_t;

endpackage

// *** bench/mufs_peer.sv ***
/*
 * Model of the remote serial peer that drives the clear-to-send pin.
 * Assumes the bench sets the wanted pin level and shares pclk and reset.
 */
`timescale 1ns/1ps
`default_nettype none

module mufs_peer (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ready_cmd,
   output logic      flow_in_pin
);
   // The pin moves only just after an edge, so the block must still
   // synchronise it; a reset peer holds the line low.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flow_in_pin <= 1'b0;
      end else begin
         flow_in_pin <= ready_cmd;
      end
   end
endmodule

`default_nettype wire

// *** bench/testbench.sv ***
/*
 * Self-checking bench for the serial port flow-control and status block.
 * Assumes the map header and package of the design and a 40 MHz clock.
 */
`include "mufs_map.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
   logic                 pclk = 1'b0;
   logic                 presetn, psel, penable, pwrite, pready, pslverr;
   logic                 flow_in_pin, flow_out_pin, cts_cmd, err;
   logic                 tx_start_req, tx_start, rx_start_req, rx_start;
   logic                 rx_drop, lsr_rd, mcr_rts;
   logic [7:0]           paddr;
   logic [3:0]           pstrb;
   logic [31:0]          pwdata, prdata, rd;
   mufs_pkg::mufs_path_t path;
   int                   n_fail = 0;
   int                   tests_run = 0;

   // ***************************************************************
   // Clock, design and peer.
   // ***************************************************************
   always #12.5 pclk = ~pclk;

   mufs_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .flow_in_pin(flow_in_pin), .flow_out_pin(flow_out_pin), .path(path),
      .tx_start_req(tx_start_req), .tx_start(tx_start),
      .rx_start_req(rx_start_req), .rx_start(rx_start), .rx_drop(rx_drop),
      .lsr_rd(lsr_rd), .mcr_rts(mcr_rts));

   mufs_peer u_peer (.pclk(pclk), .presetn(presetn), .ready_cmd(cts_cmd),
      .flow_in_pin(flow_in_pin));

   // ***************************************************************
   // Shared tasks.
   // ***************************************************************
   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Lets the two-flop pin synchroniser and registered outputs catch up.
   task automatic settle();
      repeat (4) @(posedge pclk);
      @(negedge pclk);
   endtask

   // Status word worked out from the data path inputs and the pins.
   function automatic logic [31:0] exp_stat(logic ovr, logic rtsv);
      logic [31:0] s;
      s = 32'h0;
      s[27:24] = path.tx_count;
      s[19:16] = path.rx_count;
      s[8] = (path.tx_count == 4'h0);
      s[3] = !path.tx_busy;
      s[9] = s[8] & s[3];
      s[7] = cts_cmd;
      s[6] = rtsv;
      s[5] = (path.tx_count == 4'h8);
      s[1] = !s[5];
      s[4] = ovr;
      s[2] = !path.rx_busy;
      s[0] = (path.rx_count != 4'h0);
      return s;
   endfunction

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ***************************************************************
   // Scenarios.
   // ***************************************************************
   // Reset in mid-run must bring back every listed value.
   task automatic t_reset();
      cts_cmd <= 1'b0;
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `MUFS_OFF_MODEM, 32'h0, 4'h0);
      `CHK(rd, 32'h10)
      apb(0, `MUFS_OFF_SCRATCH, 32'h0, 4'h0);
      `CHK(rd, 32'h0)
      apb(0, `MUFS_OFF_CNTL, 32'h0, 4'h0);
      `CHK(rd, 32'h03)
      apb(0, `MUFS_OFF_STAT, 32'h0, 4'h0);
      `CHK(rd, exp_stat(1'b0, 1'b1))
   endtask

   // Scratch keeps its low byte over masked and read-only writes; an unmapped read errors.
   task automatic t_scratch();
      apb(1, `MUFS_OFF_SCRATCH, 32'h1234_565a, 4'hf);
      apb(1, `MUFS_OFF_SCRATCH, 32'h0000_00a5, 4'he);
      apb(1, `MUFS_OFF_MODEM, 32'h0, 4'hf);
      apb(0, `MUFS_OFF_SCRATCH, 32'h0, 4'h0);
      `CHK(rd, 32'h5a)
      apb(0, `MUFS_OFF_MODEM, 32'h0, 4'h0);
      `CHK(rd, 32'h10)
      apb(0, 8'h10, 32'h0, 4'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
   endtask

   // Clear-to-send pin seen inverted in modem status, plain in status.
   task automatic t_cts();
      for (int p = 0; p < 2; p++) begin
         cts_cmd <= p[0];
         settle();
         apb(0, `MUFS_OFF_MODEM, 32'h0, 4'h0);
         `CHK(rd[4], !p[0])
         apb(0, `MUFS_OFF_STAT, 32'h0, 4'h0);
         `CHK(rd[7], p[0])
      end
   endtask

   // Start gating by polarity, auto flow and the two enables.
   task automatic t_tx();
      tx_start_req <= 1'b1;
      rx_start_req <= 1'b1;
      for (int l = 0; l < 2; l++) begin
         apb(1, `MUFS_OFF_CNTL, {24'h0, l[0], 3'b000, 4'b1011}, 4'hf);
         for (int p = 0; p < 2; p++) begin
            @(posedge pclk);
            cts_cmd <= p[0];
            settle();
            `CHK(tx_start, p[0] ^ l[0])
         end
      end
      apb(1, `MUFS_OFF_CNTL, 32'h03, 4'hf);
      settle();
      `CHK(tx_start, 1'b1)
      apb(1, `MUFS_OFF_CNTL, 32'h01, 4'hf);
      settle();
      `CHK({tx_start, rx_start}, 2'b01)
      apb(1, `MUFS_OFF_CNTL, 32'h02, 4'hf);
      settle();
      `CHK({tx_start, rx_start}, 2'b10)
   endtask

   // Ready line against every threshold code, count and polarity.
   task automatic t_rts();
      int   slots[4] = '{3, 2, 1, 4};
      logic e;
      for (int l = 0; l < 2; l++) begin
         for (int t = 0; t < 4; t++) begin
            apb(1, `MUFS_OFF_CNTL, {24'h0, 1'b0, l[0], t[1:0], 4'b0111},
                4'hf);
            for (int c = 0; c <= 8; c++) begin
               path.rx_count <= c[3:0];
               settle();
               e = ((8 - c) <= slots[t]) ? l[0] : !l[0];
               `CHK(flow_out_pin, e)
               apb(0, `MUFS_OFF_STAT, 32'h0, 4'h0);
               `CHK(rd[6], e)
            end
         end
      end
      apb(1, `MUFS_OFF_CNTL, 32'h03, 4'hf);
      for (int m = 1; m >= 0; m--) begin
         @(posedge pclk);
         mcr_rts <= m[0];
         settle();
         `CHK(flow_out_pin, !m[0])
      end
   endtask

   // Fill levels and flags for a table of data path states.
   task automatic t_stat();
      logic [9:0] tbl[5] = '{10'h223, 10'h000, 10'h0c6, 10'h017, 10'h201};
      logic [31:0] x;
      for (int i = 0; i < 5; i++) begin
         @(posedge pclk);
         path <= mufs_pkg::mufs_path_t'(tbl[i]);
         settle();
         apb(0, `MUFS_OFF_STAT, 32'h0, 4'h0);
         x = exp_stat(1'b0, 1'b1);
         `CHK(rd[31:8], x[31:8])
         `CHK(rd[7:0], x[7:0])
      end
   endtask

   // Overrun is sticky over status reads; only a line-status read clears.
   task automatic t_ovr();
      @(posedge pclk);
      rx_drop <= 1'b1;
      @(posedge pclk);
      rx_drop <= 1'b0;
      apb(0, `MUFS_OFF_STAT, 32'h0, 4'h0);
      apb(0, `MUFS_OFF_STAT, 32'h0, 4'h0);
      `CHK(rd[4], 1'b1)
      @(posedge pclk);
      lsr_rd <= 1'b1;
      @(posedge pclk);
      lsr_rd <= 1'b0;
      apb(0, `MUFS_OFF_STAT, 32'h0, 4'h0);
      `CHK(rd[4], 1'b0)
      // A drop beside a clear in one cycle must leave the flag set.
      @(posedge pclk);
      rx_drop <= 1'b1;
      lsr_rd  <= 1'b1;
      @(posedge pclk);
      rx_drop <= 1'b0;
      lsr_rd  <= 1'b0;
      apb(0, `MUFS_OFF_STAT, 32'h0, 4'h0);
      `CHK(rd[4], 1'b1)
   endtask

   // ***************************************************************
   // Main sequence and watchdog.
   // ***************************************************************
   initial begin
      {presetn, psel, penable, pwrite, cts_cmd, err} = 6'h0;
      {tx_start_req, rx_start_req, rx_drop, lsr_rd, mcr_rts} = 5'h0;
      paddr = 8'h00;
      pstrb = 4'h0;
      pwdata = 32'h0;
      path = '0;
      t_reset();
      t_scratch();
      t_cts();
      t_tx();
      t_rts();
      t_stat();
      t_ovr();
      t_reset();
      print_verdict();
   end

   // A hang is cut short well beyond the seven hundred or so cycles expected.
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      print_verdict();
   end
endmodule

`default_nettype wire
